// File: common/fcb_pkg.sv
`default_nettype none
package fcb_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [11:0] OFF_DISC_CFG = 12'h000;
    localparam logic [11:0] OFF_AC_PTR = 12'h004;
    localparam logic [11:0] OFF_AC_SEL = 12'h008;
    localparam logic [11:0] OFF_DC_PTR = 12'h00C;
    localparam logic [11:0] OFF_DC_SEL = 12'h010;
    localparam logic [11:0] OFF_MANUAL = 12'h014;
    localparam logic [11:0] OFF_WRN_OFF = 12'h018;
    localparam logic [11:0] OFF_WRN_TRIP = 12'h01C;
    localparam logic [11:0] OFF_WRN_AHOLD = 12'h020;
    localparam logic [11:0] OFF_WRN_RHOLD = 12'h024;
    localparam logic [11:0] OFF_WRN_STICKY = 12'h028;
    localparam logic [11:0] OFF_STATUS = 12'h02C;
    localparam logic [11:0] OFF_TEMP = 12'h030;
    localparam logic [11:0] OFF_GRP_BASE = 12'h100;
    localparam logic [11:0] OFF_GRP_STRIDE = 12'h020;
    localparam logic [11:0] OFF_MAP_BASE = 12'h200;
    localparam logic [11:0] OFF_MAP_STRIDE = 12'h100;

    // Address that a source pointer holds to select the aggregate trigger.
    localparam logic [31:0] ADDR_AGG_TRIG = 32'h0000_0040;

    // Summary groups: 0 fault, 1 warning, 2 user.
    localparam int NGRP = 3;
    localparam int NBITS = 63;
    localparam logic [31:0] GRP_WIDTH = 32'h0000_003F;

    // Reset values.
    localparam logic [1:0] RST_DISC_CFG = 2'h0;
    localparam logic [31:0] RST_WRN_OFF = 32'h0000_0001;
    localparam logic [31:0] RST_WRN_TRIP = 32'h0000_0001;
    localparam logic [31:0] RST_WRN_AHOLD = 32'h0000_0000;
    localparam logic [31:0] RST_WRN_RHOLD = 32'h001E_8480;
    localparam logic [31:0] RST_WRN_STICKY = 32'h0000_0000;

    // Quick disconnect reaction: contactor drops 3 cycles after the filtered edge (QUICK_CYC of 2 counted, then the cut is registered).
    localparam int QUICK_DELAY_NS = 10;
    localparam int CLK_NS = 5;
    localparam logic [3:0] QUICK_CYC = 4'(QUICK_DELAY_NS / CLK_NS);

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hsel;
        logic hready;
    } fcb_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } fcb_ahb_rsp_t;

    typedef struct packed {
        logic [NBITS-1:0] active;
        logic [NBITS-1:0] ready;
    } fcb_grp_t;

endpackage
`default_nettype wire

// File: rtl/fcb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_top
    import fcb_pkg::*;
#(
    parameter logic [NGRP*NBITS*32-1:0] MAP_TABLE = '0
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AHB-Lite register slave.
    input wire fcb_ahb_req_t ahb_i,
    output fcb_ahb_rsp_t ahb_o,
    // Disconnect pin and contactor drive.
    input wire logic disc_pin_i,
    input wire logic contactor_req_i,
    output logic contactor_drive_o,
    output logic sw_disc_req_o,
    // Fan control triggers and fan drivers.
    input wire logic fan_trig_charge_i,
    input wire logic fan_trig_discharge_i,
    input wire logic [15:0] max_cell_temp_i,
    input wire logic dc_fan_fail_i,
    output logic ac_fan_driver_o,
    output logic dc_fan_driver_o,
    output logic dc_fan_failure_warning_o,
    // Trigger summary inputs.
    input wire fcb_grp_t [NGRP-1:0] grp_i,
    input wire logic [NGRP*NBITS-1:0] grp_valid_i
);

    typedef struct packed {
        logic [2:0] pin_sync;
        logic disc_act;
        logic [3:0] quick_cnt;
        logic cut;
        logic [1:0] disc_cfg;
        logic [31:0] ac_ptr;
        logic ac_sel;
        logic [31:0] dc_ptr;
        logic dc_sel;
        logic [1:0] manual;
        logic [31:0] wrn_off;
        logic [31:0] wrn_trip;
        logic [31:0] wrn_ahold;
        logic [31:0] wrn_rhold;
        logic [31:0] wrn_sticky;
        logic [31:0] wrn_cnt;
        logic wrn;
        logic agg;
        logic [15:0] temp;
        logic ac_fan;
        logic dc_fan;
        logic contactor;
        logic sw_req;
        fcb_grp_t [NGRP-1:0] grp;
        logic [11:0] addr;
        logic pend;
        logic [31:0] rdata;
    } fcb_state_t;

    fcb_state_t s_q, s_d;

    // Value of the aggregate trigger if a source pointer names it, else 0.
    function automatic logic source_val(input logic [31:0] ptr,
                                        input logic agg);
        source_val = (ptr == ADDR_AGG_TRIG) ? agg : 1'b0;
    endfunction

    function automatic logic [31:0] read_reg(input fcb_state_t s,
                                             input logic [11:0] a);
        logic [31:0] r;
        int g;
        int b;
        r = 32'h0000_0000;
        case (a)
            OFF_DISC_CFG: r = {30'h0, s.disc_cfg};
            OFF_AC_PTR: r = s.ac_ptr;
            OFF_AC_SEL: r = {31'h0, s.ac_sel};
            OFF_DC_PTR: r = s.dc_ptr;
            OFF_DC_SEL: r = {31'h0, s.dc_sel};
            OFF_MANUAL: r = {30'h0, s.manual};
            OFF_WRN_OFF: r = s.wrn_off;
            OFF_WRN_TRIP: r = s.wrn_trip;
            OFF_WRN_AHOLD: r = s.wrn_ahold;
            OFF_WRN_RHOLD: r = s.wrn_rhold;
            OFF_WRN_STICKY: r = s.wrn_sticky;
            OFF_STATUS: r = {25'h0, s.disc_act, s.cut, s.sw_req, s.wrn,
                             s.dc_fan, s.ac_fan, s.agg};
            OFF_TEMP: r = {16'h0, s.temp};
            default: begin
                for (g = 0; g < NGRP; g++) begin
                    if (a == OFF_GRP_BASE + 12'(g) * OFF_GRP_STRIDE) begin
                        r = GRP_WIDTH;
                    end
                    if (a == OFF_GRP_BASE + 12'(g) * OFF_GRP_STRIDE
                        + 12'h004) begin
                        r = s.grp[g].active[31:0];
                    end
                    if (a == OFF_GRP_BASE + 12'(g) * OFF_GRP_STRIDE
                        + 12'h008) begin
                        r = {1'b0, s.grp[g].active[NBITS-1:32]};
                    end
                    if (a == OFF_GRP_BASE + 12'(g) * OFF_GRP_STRIDE
                        + 12'h00C) begin
                        r = s.grp[g].ready[31:0];
                    end
                    if (a == OFF_GRP_BASE + 12'(g) * OFF_GRP_STRIDE
                        + 12'h010) begin
                        r = {1'b0, s.grp[g].ready[NBITS-1:32]};
                    end
                    // Helper entry b sits at word b of its map.
                    for (b = 0; b < NBITS; b++) begin
                        if (a == OFF_MAP_BASE + 12'(g) * OFF_MAP_STRIDE
                            + 12'(b * 4)) begin
                            r = MAP_TABLE[(g*NBITS+b)*32 +: 32];
                        end
                    end
                end
            end
        endcase
        return r;
    endfunction

    logic ahb_go;
    assign ahb_go = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];

    always_comb begin
        logic pin_now;
        logic fail_hi;
        s_d = s_q;
        pin_now = 1'b0;
        fail_hi = 1'b0;

        // Three-stage synchroniser; accept a change when stages 2 and 3 agree.
        s_d.pin_sync = {s_q.pin_sync[1:0], disc_pin_i};
        if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
            pin_now = s_q.pin_sync[2] ~^ s_q.disc_cfg[1];
            s_d.disc_act = pin_now;
        end

        // Mode bit 0: quick cuts all contactors together.
        // The cut lasts only while the request stands, so a short pulse
        // on the pin leaves the contactors dropped for a few cycles only.
        if (s_q.disc_act && s_q.disc_cfg[0]) begin
            if (s_q.quick_cnt < QUICK_CYC) begin
                s_d.quick_cnt = s_q.quick_cnt + 4'h1;
            end else begin
                s_d.cut = 1'b1;
            end
        end else begin
            s_d.quick_cnt = 4'h0;
            s_d.cut = 1'b0;
        end
        s_d.contactor = contactor_req_i && !s_d.cut;
        s_d.sw_req = s_q.disc_act && !s_q.disc_cfg[0];

        // Fan decision and temperature tracking stay out of the summaries.
        s_d.temp = max_cell_temp_i;
        s_d.agg = fan_trig_charge_i | fan_trig_discharge_i;
        s_d.ac_fan = s_q.ac_sel ? source_val(s_q.ac_ptr, s_q.agg)
                                : s_q.manual[0];
        s_d.dc_fan = s_q.dc_sel ? source_val(s_q.dc_ptr, s_q.agg)
                                : s_q.manual[1];

        // DC fan failure hysteresis; a missing fan reads as failed.
        fail_hi = {31'h0, dc_fan_fail_i} >= s_q.wrn_trip;
        if (s_q.wrn_off[0]) begin
            s_d.wrn = 1'b0;
            s_d.wrn_cnt = 32'h0;
        end else if (fail_hi != s_q.wrn) begin
            // Sticky mode holds a raised warning until it is disabled.
            if (!fail_hi && s_q.wrn_sticky[0]) begin
                s_d.wrn_cnt = 32'h0;
            end else if (s_q.wrn_cnt >=
                         (fail_hi ? s_q.wrn_ahold : s_q.wrn_rhold)) begin
                s_d.wrn = fail_hi;
                s_d.wrn_cnt = 32'h0;
            end else begin
                s_d.wrn_cnt = s_q.wrn_cnt + 32'h1;
            end
        end else begin
            s_d.wrn_cnt = 32'h0;
        end

        // Summaries, fixed bit positions; bit 63 does not exist.
        for (int g = 0; g < NGRP; g++) begin
            s_d.grp[g].active = grp_i[g].active;
            s_d.grp[g].ready = s_q.grp[g].ready
                | grp_valid_i[g*NBITS +: NBITS];
        end

        // AHB-Lite zero-wait slave, always OKAY.
        s_d.pend = ahb_go && ahb_i.hwrite;
        if (ahb_go) begin
            s_d.addr = ahb_i.haddr[11:0];
            s_d.rdata = read_reg(s_q, ahb_i.haddr[11:0]);
        end
        if (s_q.pend) begin
            case (s_q.addr)
                OFF_DISC_CFG: s_d.disc_cfg = ahb_i.hwdata[1:0];
                OFF_AC_PTR: s_d.ac_ptr = ahb_i.hwdata;
                OFF_AC_SEL: s_d.ac_sel = ahb_i.hwdata[0];
                OFF_DC_PTR: s_d.dc_ptr = ahb_i.hwdata;
                OFF_DC_SEL: s_d.dc_sel = ahb_i.hwdata[0];
                OFF_MANUAL: s_d.manual = ahb_i.hwdata[1:0];
                OFF_WRN_OFF: s_d.wrn_off = ahb_i.hwdata;
                OFF_WRN_TRIP: s_d.wrn_trip = ahb_i.hwdata;
                OFF_WRN_AHOLD: s_d.wrn_ahold = ahb_i.hwdata;
                OFF_WRN_RHOLD: s_d.wrn_rhold = ahb_i.hwdata;
                OFF_WRN_STICKY: s_d.wrn_sticky = ahb_i.hwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.disc_cfg <= RST_DISC_CFG;
            s_q.wrn_off <= RST_WRN_OFF;
            s_q.wrn_trip <= RST_WRN_TRIP;
            s_q.wrn_ahold <= RST_WRN_AHOLD;
            s_q.wrn_rhold <= RST_WRN_RHOLD;
            s_q.wrn_sticky <= RST_WRN_STICKY;
        end else begin
            s_q <= s_d;
        end
    end

    // Only the DC path has a failure warning output.
    assign ahb_o.hrdata = s_q.rdata;
    assign ahb_o.hreadyout = 1'b1;
    assign ahb_o.hresp = 1'b0;
    assign contactor_drive_o = s_q.contactor;
    assign sw_disc_req_o = s_q.sw_req;
    assign ac_fan_driver_o = s_q.ac_fan;
    assign dc_fan_driver_o = s_q.dc_fan;
    assign dc_fan_failure_warning_o = s_q.wrn;

    // Disconnect path checks.
    quick_cut_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.disc_act && s_q.disc_cfg[0] && $stable(s_q.disc_cfg)
        |-> ##[0:4] !contactor_drive_o)
        else $error("quick cut late");
    contactor_req_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !contactor_req_i
        |=> !contactor_drive_o)
        else $error("contactor driven without request");
    nominal_nocut_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !s_q.disc_cfg[0] && contactor_req_i
        |=> contactor_drive_o)
        else $error("nominal mode cut contactors");
    cut_quick_only_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !s_q.disc_cfg[0]
        |=> !s_q.cut)
        else $error("cut outside quick mode");
    sw_req_nom_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.disc_act && !s_q.disc_cfg[0]
        |=> sw_disc_req_o)
        else $error("nominal request not raised");
    sw_req_quick_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.disc_cfg[0]
        |=> !sw_disc_req_o)
        else $error("software request in quick mode");

    // Fan path checks.
    fan_or_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (fan_trig_charge_i || fan_trig_discharge_i)
        |=> s_q.agg)
        else $error("aggregate missed a trigger");
    fan_agg_low_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !fan_trig_charge_i && !fan_trig_discharge_i
        |=> !s_q.agg)
        else $error("aggregate set without trigger");
    fan_manual_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !s_q.ac_sel
        |=> ac_fan_driver_o == $past(s_q.manual[0]))
        else $error("AC manual not followed");
    dc_manual_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !s_q.dc_sel
        |=> dc_fan_driver_o == $past(s_q.manual[1]))
        else $error("DC manual not followed");
    fan_source_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.dc_sel && s_q.dc_ptr == ADDR_AGG_TRIG
        |=> dc_fan_driver_o == $past(s_q.agg))
        else $error("DC fan not following source");
    ac_source_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.ac_sel && s_q.ac_ptr == ADDR_AGG_TRIG
        |=> ac_fan_driver_o == $past(s_q.agg))
        else $error("AC fan not following source");
    dc_ptr_other_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.dc_sel && s_q.dc_ptr != ADDR_AGG_TRIG
        |=> !dc_fan_driver_o)
        else $error("DC fan driven from empty source");
    temp_track_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        1'b1
        |=> s_q.temp == $past(max_cell_temp_i))
        else $error("temperature not tracked");

    // Warning checks.
    warn_off_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.wrn_off[0]
        |=> !dc_fan_failure_warning_o)
        else $error("warning while disabled");
    warn_rise_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(dc_fan_failure_warning_o)
        |-> $past(dc_fan_fail_i))
        else $error("warning without failure");
    warn_sticky_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.wrn && s_q.wrn_sticky[0] && !s_q.wrn_off[0]
        |=> dc_fan_failure_warning_o)
        else $error("sticky warning dropped");

    // Summary checks.
    ready_keep_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_q.grp[0].ready[0]
        |=> s_q.grp[0].ready[0])
        else $error("ready bit dropped");
    ready_set_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        grp_valid_i[0]
        |=> s_q.grp[0].ready[0])
        else $error("ready bit not set");
    act_follow_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        1'b1
        |=> s_q.grp[1].active == $past(grp_i[1].active))
        else $error("summary bits not captured");

endmodule
`default_nettype wire

// File: tb/fcb_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_far_side #(
    parameter int HOLD_CYC = 16
) (
    // Clock.
    input wire logic ref_clk_i,
    // Stimulus from the bench.
    input wire logic fan_fitted_i,
    input wire logic disc_req_i,
    input wire logic active_high_i,
    // Lines towards the block.
    output logic disc_pin_o,
    output logic dc_fan_fail_o
);
    int cnt_q = 0;
    // The fan driver reports a failure whenever no DC fan is fitted.
    assign dc_fan_fail_o = !fan_fitted_i;
    // Each request is stretched to the minimum assertion period.
    always @(posedge ref_clk_i) begin
        if (disc_req_i) begin
            cnt_q <= HOLD_CYC;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign disc_pin_o = (cnt_q > 0) ~^ active_high_i;
endmodule
`default_nettype wire

// File: tb/fan_control_and_trigger_bitfields_test.sv
`timescale 1ns/1ps
`default_nettype none
module fan_control_and_trigger_bitfields_test;
    import fcb_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    fcb_ahb_req_t req = '0;
    fcb_ahb_req_t req_w;
    fcb_ahb_rsp_t rsp;
    logic pin, fail, creq = 1'b1, tc = 1'b0, td = 1'b0;
    logic fitted = 1'b1, dreq = 1'b0, ahi = 1'b1;
    fcb_grp_t [NGRP-1:0] grp = '0;
    logic [NGRP*NBITS-1:0] gvld = '0;
    logic drive, swreq, ac, dc, wrn;
    logic [31:0] rd;
    int n_mismatch = 0, checked = 0, cyc = 0;
    function automatic logic [NGRP*NBITS*32-1:0] mk_map();
        logic [NGRP*NBITS*32-1:0] m;
        for (int i = 0; i < NGRP*NBITS; i++) begin
            m[i*32 +: 32] = 32'h0A00_0000 + 32'(i);
        end
        return m;
    endfunction
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always_comb begin
        req_w = req;
        req_w.hready = rsp.hreadyout;
    end
    fcb_far_side #(.HOLD_CYC(16)) far_u (.ref_clk_i(ref_clk_i),
        .fan_fitted_i(fitted), .disc_req_i(dreq), .active_high_i(ahi),
        .disc_pin_o(pin), .dc_fan_fail_o(fail));
    fcb_top #(.MAP_TABLE(mk_map())) dut_u (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .ahb_i(req_w), .ahb_o(rsp), .disc_pin_i(pin),
        .contactor_req_i(creq), .contactor_drive_o(drive),
        .sw_disc_req_o(swreq), .fan_trig_charge_i(tc),
        .fan_trig_discharge_i(td), .max_cell_temp_i(16'h0123),
        .dc_fan_fail_i(fail), .ac_fan_driver_o(ac), .dc_fan_driver_o(dc),
        .dc_fan_failure_warning_o(wrn), .grp_i(grp), .grp_valid_i(gvld));
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ahb(logic w, logic [11:0] a, logic [31:0] wd);
        @(posedge ref_clk_i);
        req.haddr <= {20'h0, a};
        req.htrans <= 2'h2;
        req.hwrite <= w;
        req.hsize <= 3'h2;
        req.hsel <= 1'b1;
        do @(posedge ref_clk_i); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= wd;
        do @(posedge ref_clk_i); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask
    task automatic rdc(string nm, logic [11:0] a, logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(nm, {32'h0, rd}, {32'h0, exp});
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic t_reset();
        logic [11:0] a [5] = '{OFF_WRN_OFF, OFF_WRN_TRIP, OFF_WRN_AHOLD,
            OFF_WRN_RHOLD, OFF_WRN_STICKY};
        logic [31:0] e [5] = '{32'h1, 32'h1, 32'h0, 32'h001E_8480, 32'h0};
        for (int i = 0; i < 5; i++) begin
            rdc("wrn_rst", a[i], e[i]);
        end
        ahb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        rdc("unmapped", 12'h0FC, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_sum();
        logic [62:0] act;
        logic [11:0] b;
        logic [11:0] m;
        for (int g = 0; g < NGRP; g++) begin
            act = 63'h5A5A_0000_8000_0001 + 63'(g);
            grp[g].active <= act;
            b = OFF_GRP_BASE + 12'(g) * OFF_GRP_STRIDE;
            m = OFF_MAP_BASE + 12'(g) * OFF_MAP_STRIDE;
            rdc("width", b, 32'h3F);
            rdc("rdy_pre", b + 12'h00C, 32'h0);
            gvld[g*NBITS] <= 1'b1;
            gvld[g*NBITS+62] <= 1'b1;
            @(posedge ref_clk_i);
            gvld <= '0;
            rdc("act_lo", b + 12'h004, act[31:0]);
            rdc("act_hi", b + 12'h008, {1'b0, act[62:32]});
            rdc("rdy_lo", b + 12'h00C, 32'h1);
            rdc("rdy_hi", b + 12'h010, 32'h4000_0000);
            rdc("map0", m, 32'h0A00_0000 + 32'(g*NBITS));
            rdc("map62", m + 12'h0F8,
                32'h0A00_0000 + 32'(g*NBITS+62));
        end
        $display("test summary done");
    endtask
    task automatic t_fans();
        ahb(1'b1, OFF_AC_SEL, 32'h0);
        ahb(1'b1, OFF_DC_SEL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, OFF_MANUAL, 32'(i));
            wt(3);
            chk("ac_man", 64'(ac), 64'(i & 1));
            chk("dc_man", 64'(dc), 64'(i >> 1));
        end
        ahb(1'b1, OFF_AC_PTR, ADDR_AGG_TRIG);
        ahb(1'b1, OFF_DC_PTR, ADDR_AGG_TRIG);
        ahb(1'b1, OFF_AC_SEL, 32'h1);
        ahb(1'b1, OFF_DC_SEL, 32'h1);
        // Manual bits remain set, so idle fans prove the override.
        for (int t = 0; t < 4; t++) begin
            @(posedge ref_clk_i);
            tc <= t[0];
            td <= t[1];
            wt(4);
            chk("ac_auto", 64'(ac), 64'(t != 0));
            chk("dc_auto", 64'(dc), 64'(t != 0));
            chk("no_wrn", 64'(wrn), 64'h0);
        end
        ahb(1'b1, OFF_DC_PTR, 32'h0);
        wt(3);
        chk("dc_ptr0", 64'(dc), 64'h0);
        chk("ac_kept", 64'(ac), 64'h1);
        rdc("temp", OFF_TEMP, 32'h0000_0123);
        $display("test fans done");
    endtask
    task automatic t_warn();
        @(posedge ref_clk_i);
        fitted <= 1'b0;
        wt(6);
        chk("wrn_off", 64'(wrn), 64'h0);
        ahb(1'b1, OFF_WRN_RHOLD, 32'h4);
        ahb(1'b1, OFF_WRN_OFF, 32'h0);
        wt(4);
        chk("wrn_on", 64'(wrn), 64'h1);
        @(posedge ref_clk_i);
        fitted <= 1'b1;
        wt(2);
        chk("wrn_hold", 64'(wrn), 64'h1);
        wt(8);
        chk("wrn_rel", 64'(wrn), 64'h0);
        ahb(1'b1, OFF_WRN_STICKY, 32'h1);
        @(posedge ref_clk_i);
        fitted <= 1'b0;
        wt(4);
        chk("wrn_set2", 64'(wrn), 64'h1);
        @(posedge ref_clk_i);
        fitted <= 1'b1;
        wt(10);
        chk("wrn_stuck", 64'(wrn), 64'h1);
        ahb(1'b1, OFF_WRN_OFF, 32'h1);
        wt(3);
        chk("wrn_clr", 64'(wrn), 64'h0);
        $display("test warning done");
    endtask
    task automatic t_disc();
        ahb(1'b1, OFF_DISC_CFG, 32'h2);
        wt(4);
        chk("sw_idle", 64'(swreq), 64'h0);
        @(posedge ref_clk_i);
        creq <= 1'b0;
        wt(3);
        chk("drv_noreq", 64'(drive), 64'h0);
        @(posedge ref_clk_i);
        creq <= 1'b1;
        dreq <= 1'b1;
        @(posedge ref_clk_i);
        dreq <= 1'b0;
        wt(10);
        chk("sw_req", 64'(swreq), 64'h1);
        chk("drv_nom", 64'(drive), 64'h1);
        wt(30);
        @(posedge ref_clk_i);
        ahi <= 1'b0;
        ahb(1'b1, OFF_DISC_CFG, 32'h1);
        wt(30);
        chk("drv_idle", 64'(drive), 64'h1);
        @(posedge ref_clk_i);
        dreq <= 1'b1;
        @(posedge ref_clk_i);
        dreq <= 1'b0;
        wt(10);
        chk("drv_cut", 64'(drive), 64'h0);
        chk("sw_quick", 64'(swreq), 64'h0);
        $display("test disconnect done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sum();
        t_fans();
        t_warn();
        t_disc();
        conclude();
    end
endmodule
`default_nettype wire
